// File: ccrc_map.vh
`ifndef CCRC_MAP_VH
`define CCRC_MAP_VH

// register indexes; byte address is four times the index
`define CCRC_IDX_DATA0    16'hA07C
`define CCRC_IDX_DATA1    16'hA07D
`define CCRC_IDX_DATA2    16'hA07E
`define CCRC_IDX_DATA3    16'hA07F
`define CCRC_IDX_CTRL     16'hA07B

// control register fields
`define CCRC_CTRL_MODE_LO 0
`define CCRC_CTRL_MODE_HI 2
`define CCRC_CTRL_NOCY    3
`define CCRC_CTRL_SEED    4
`define CCRC_CTRL_REV     5
`define CCRC_CTRL_WID_LO  6
`define CCRC_CTRL_WID_HI  7
`define CCRC_CTRL_BUSY    8
`define CCRC_CTRL_RST     8'h00

// mode select codes
`define CCRC_MODE_OFF     3'h0
`define CCRC_MODE_CS8     3'h1
`define CCRC_MODE_CS32    3'h2
`define CCRC_MODE_CRC16A  3'h3
`define CCRC_MODE_CRC16C  3'h4
`define CCRC_MODE_CRC32   3'h5
`define CCRC_MODE_RSVD    3'h6
`define CCRC_MODE_CLEAR   3'h7

// polynomials, top bit implied
`define CCRC_POLY_16A     32'h0000_8005
`define CCRC_POLY_16C     32'h0000_1021
`define CCRC_POLY_32      32'h04C1_1DB7

// default seeds and reset values
`define CCRC_SEED_CS      32'h0000_0000
`define CCRC_SEED_CRC16   32'h0000_FFFF
`define CCRC_SEED_CRC32   32'hFFFF_FFFF
`define CCRC_DATA_RST     8'h00

// engine latency in clock cycles from the low byte write
`define CCRC_CALC_CYCLES  2

`endif

// File: ccrc_accel.v
// Summary of operation
// R1 - carry_discard 0 folds previous checksum carry into the sum; 1 drops it
// R2 - with seed entry set, low byte write loads the seed instead of data
// R3 - seed loads keep their bit order regardless of input bit reversal
// R4 - mode 000 disables the engine; its state holds as if clock gated; a 111 write here still zeroes result and carry
// R5 - mode 001 is 8-bit checksum, mode 010 is 32-bit checksum
// R6 - mode 011 is CRC-16 with polynomial 8005
// R7 - mode 100 is CCITT CRC-16 with polynomial 1021
// R8 - mode 101 is CRC-32 polynomial 104C11DB7; mode 110 computes nothing
// R9 - writing 111 clears state: seed zero for checksums, all ones for CRCs
// R10 - software sets the mode, then writes 111, before entering any data
// R11 - busy reads 1 while a result is pending, 0 once complete
// R12 - each calculation finishes within two clock cycles of the low byte write
// R13 - at 8-bit width software uses only the lowest data byte
// R14 - high bytes are written first; the low byte write starts the calculation
// R15 - data port reads return the result in natural bit order
// R16 - width codes 0..3 feed 8..32 bits; reversal mirrors that word first
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "ccrc_map.vh"

module ccrc_accel (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        srst_i,
	// wishbone classic slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [17:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// status
	output wire        busy_o
);

	// control state
	reg  [2:0]  accel_mode_select;
	reg  [2:0]  run_mode;
	reg         carry_discard;
	reg         seed_entry;
	reg         bit_reverse;
	reg  [1:0]  input_width_select;

	// data port and engine state
	reg  [7:0]  hold_b1;
	reg  [7:0]  hold_b2;
	reg  [7:0]  hold_b3;
	reg  [31:0] result;
	reg         carry;
	reg         calc_go;
	reg  [31:0] engine_input_word;

	wire        req;
	wire        wr;
	wire [15:0] idx;
	wire [31:0] port_word;
	wire        low_wr;
	reg  [31:0] next_result;
	reg         next_carry;
	reg  [31:0] rd_word;
	wire        wr_ctl;
	wire        wr_d1;
	wire        wr_d2;
	wire        wr_d3;
	wire        rd_take;
	wire [2:0]  wr_mode;
	wire        wr_clear;
	wire        calc_start;
	wire        seed_load;
	wire [31:0] masked_word;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[17:2];
	assign port_word = {hold_b3, hold_b2, hold_b1, wb_dat_i[7:0]};
	assign low_wr = wr && idx == `CCRC_IDX_DATA0;
	assign busy_o = calc_go; // see R11

	// per-register strobes, valid only on the take edge
	assign wr_ctl = wr && idx == `CCRC_IDX_CTRL;
	assign wr_d1 = wr && idx == `CCRC_IDX_DATA1;
	assign wr_d2 = wr && idx == `CCRC_IDX_DATA2;
	assign wr_d3 = wr && idx == `CCRC_IDX_DATA3;
	assign rd_take = req && !wb_we_i;
	assign wr_mode = wb_dat_i[`CCRC_CTRL_MODE_HI:`CCRC_CTRL_MODE_LO];
	assign wr_clear = wr_ctl && wr_mode == `CCRC_MODE_CLEAR;
	// disabled mode ignores low byte writes, standing in for the gated clock
	assign seed_load = low_wr && run_mode != `CCRC_MODE_OFF && seed_entry; // see R2 R4
	assign calc_start = low_wr && run_mode != `CCRC_MODE_OFF && run_mode != `CCRC_MODE_RSVD
		&& !seed_entry; // see R4 R8 R14
	// seeds keep the written bit order
	assign masked_word = port_word & width_mask(input_width_select); // see R3

	// number of input bits for a width code
	function [5:0] width_bits;
		input [1:0] ws;
		begin
			width_bits = {1'b0, ws, 3'b000} + 6'd8;
		end
	endfunction

	// mirror the low n bits of a word; n is 8, 16, 24 or 32
	function [31:0] mirror;
		input [31:0] w;
		input [1:0]  ws;
		integer i;
		reg [31:0] r;
		begin
			r = 32'h0000_0000;
			for (i = 0; i < 32; i = i + 1) begin
				r[31 - i] = w[i];
			end
			mirror = r >> (6'd32 - width_bits(ws));
		end
	endfunction

	// mask a word to the selected input width
	function [31:0] width_mask;
		input [1:0] ws;
		begin
			width_mask = 32'hFFFF_FFFF >> (6'd32 - width_bits(ws));
		end
	endfunction

	// align and optionally mirror the port word for the engine
	function [31:0] shape_input;
		input [31:0] w;
		input [1:0]  ws;
		input        rev;
		begin
			if (rev) begin
				shape_input = mirror(w, ws);
			end else begin
				shape_input = w & width_mask(ws);
			end
		end
	endfunction

	// msb first crc over the low n bits of d
	function [31:0] crc_step;
		input [31:0] c;
		input [31:0] d;
		input [1:0]  ws;
		input [31:0] poly;
		input        wide;
		integer i;
		reg [31:0] r;
		reg        fb;
		begin
			r = c;
			for (i = 31; i >= 0; i = i - 1) begin
				// a 16-bit crc lets junk pile up above bit 15; only [15:0] is kept
				if (i < width_bits(ws)) begin
					fb = d[i] ^ (wide ? r[31] : r[15]);
					r = {r[30:0], 1'b0};
					if (fb) begin
						r = r ^ poly;
					end
				end
			end
			crc_step = wide ? r : {16'h0000, r[15:0]};
		end
	endfunction

	// checksum add with carry-in; narrow form keeps only the low byte
	function [32:0] cs_add;
		input [31:0] a;
		input [31:0] b;
		input        cin;
		input        wide;
		reg   [8:0]  s8;
		begin
			s8 = 9'h000;
			if (wide) begin
				cs_add = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
			end else begin
				s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
				cs_add = {s8[8], 24'h00_0000, s8[7:0]};
			end
		end
	endfunction

	// default seed for the mode being run
	function [31:0] seed_for;
		input [2:0] m;
		begin
			case (m)
				`CCRC_MODE_CS8: seed_for = `CCRC_SEED_CS;
				`CCRC_MODE_CS32: seed_for = `CCRC_SEED_CS;
				`CCRC_MODE_CRC16A: seed_for = `CCRC_SEED_CRC16;
				`CCRC_MODE_CRC16C: seed_for = `CCRC_SEED_CRC16;
				`CCRC_MODE_CRC32: seed_for = `CCRC_SEED_CRC32;
				default: seed_for = `CCRC_SEED_CS;
			endcase
		end
	endfunction

	// one byte lane of the result, zero extended to the bus
	function [31:0] result_byte;
		input [31:0] r;
		input [1:0]  lane;
		begin
			result_byte = {24'h00_0000, r[{lane, 3'b000} +: 8]};
		end
	endfunction

	// engine arithmetic
	always @* begin
		next_result = result;
		next_carry = carry;
		case (run_mode)
			`CCRC_MODE_CS8: begin
				// see R5
				{next_carry, next_result} = cs_add(result, engine_input_word, carry & ~carry_discard, 1'b0); // see R1
			end
			`CCRC_MODE_CS32: begin
				{next_carry, next_result} = cs_add(result, engine_input_word, carry & ~carry_discard, 1'b1); // see R1 R5
			end
			`CCRC_MODE_CRC16A: begin
				next_result = crc_step(result, engine_input_word, input_width_select, `CCRC_POLY_16A, 1'b0); // see R6
			end
			`CCRC_MODE_CRC16C: begin
				next_result = crc_step(result, engine_input_word, input_width_select, `CCRC_POLY_16C, 1'b0); // see R7
			end
			`CCRC_MODE_CRC32: begin
				next_result = crc_step(result, engine_input_word, input_width_select, `CCRC_POLY_32, 1'b1); // see R8
			end
			default: begin
				// reserved and disabled codes leave the state alone
				next_result = result; // see R8
			end
		endcase
	end

	// control register; clear keeps the mode chosen before it
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			accel_mode_select <= `CCRC_MODE_OFF;
			run_mode <= `CCRC_MODE_OFF;
			carry_discard <= 1'b0;
			seed_entry <= 1'b0;
			bit_reverse <= 1'b0;
			input_width_select <= 2'h0;
		end else if (wr_ctl) begin
			accel_mode_select <= wr_mode;
			carry_discard <= wb_dat_i[`CCRC_CTRL_NOCY];
			seed_entry <= wb_dat_i[`CCRC_CTRL_SEED];
			bit_reverse <= wb_dat_i[`CCRC_CTRL_REV];
			input_width_select <= wb_dat_i[`CCRC_CTRL_WID_HI:`CCRC_CTRL_WID_LO];
			if (!wr_clear) begin
				run_mode <= wr_mode;
			end
		end
	end

	// upper data bytes only wait for the low byte write
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			hold_b1 <= `CCRC_DATA_RST;
			hold_b2 <= `CCRC_DATA_RST;
			hold_b3 <= `CCRC_DATA_RST;
		end else begin
			if (wr_d1) begin
				hold_b1 <= wb_dat_i[7:0]; // see R14
			end
			if (wr_d2) begin
				hold_b2 <= wb_dat_i[7:0];
			end
			if (wr_d3) begin
				hold_b3 <= wb_dat_i[7:0];
			end
		end
	end

	// input word latch and one-cycle busy
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			calc_go <= 1'b0;
			engine_input_word <= 32'h0000_0000;
		end else begin
			calc_go <= calc_start; // see R11 R14
			if (calc_start) begin
				engine_input_word <= shape_input(port_word, input_width_select, bit_reverse); // see R16
			end
		end
	end

	// result and carry; clear and seed never meet a landing result, the bus is acked then
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			result <= `CCRC_SEED_CS;
			carry <= 1'b0;
		end else if (wr_clear) begin
			result <= seed_for(run_mode); // see R9
			carry <= 1'b0;
		end else if (seed_load) begin
			// seed taken as written, never mirrored
			result <= masked_word; // see R2 R3
			carry <= 1'b0;
		end else if (calc_go) begin
			// second cycle: result and carry land, busy drops
			result <= next_result; // see R12
			carry <= next_carry;
		end
	end

	// read mux; result bytes come back unmirrored
	always @* begin
		case (idx)
			`CCRC_IDX_DATA0: rd_word = result_byte(result, 2'h0); // see R15
			`CCRC_IDX_DATA1: rd_word = result_byte(result, 2'h1);
			`CCRC_IDX_DATA2: rd_word = result_byte(result, 2'h2);
			`CCRC_IDX_DATA3: rd_word = result_byte(result, 2'h3);
			`CCRC_IDX_CTRL: begin
				rd_word = 32'h0000_0000;
				rd_word[`CCRC_CTRL_MODE_HI:`CCRC_CTRL_MODE_LO] = accel_mode_select;
				rd_word[`CCRC_CTRL_NOCY] = carry_discard;
				rd_word[`CCRC_CTRL_SEED] = seed_entry;
				rd_word[`CCRC_CTRL_REV] = bit_reverse;
				rd_word[`CCRC_CTRL_WID_HI:`CCRC_CTRL_WID_LO] = input_width_select;
				rd_word[`CCRC_CTRL_BUSY] = calc_go; // see R11
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// one wait state; unmapped words read zero and still ack
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req; // see R12
		end
	end

	// read data holds until the next read is taken
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_take) begin
			wb_dat_o <= rd_word;
		end
	end

endmodule // ccrc_accel
`default_nettype wire

// File: ccrc_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccrc_map.vh"
module ccrc_properties (
	// clock, reset
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [17:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// status
	input wire logic        busy_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire rdd = tk && !wb_we_i && wb_adr_i[17:2] inside {[`CCRC_IDX_DATA0:`CCRC_IDX_DATA3]};
	wire lw = tk && wb_we_i && wb_sel_i[0] && wb_adr_i[17:2] == `CCRC_IDX_DATA0;
	property p_lat; tk |=> wb_ack_o; endproperty
	a_lat: assert property (p_lat) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack long");
	property p_cause; wb_ack_o |-> $past(tk); endproperty
	a_cause: assert property (p_cause) else $error("stray ack");
	property p_bsrc; busy_o |-> $past(lw); endproperty
	a_bsrc: assert property (p_bsrc) else $error("busy not from low byte");
	property p_bshort; busy_o |=> !busy_o; endproperty
	a_bshort: assert property (p_bshort) else $error("busy too long");
	property p_hold; !(tk && !wb_we_i) |=> $stable(wb_dat_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_upper; rdd |=> wb_dat_o[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper lanes set");
	property p_rst; disable iff (1'b0) srst_i |=> !wb_ack_o && !busy_o && wb_dat_o == 32'h0000_0000; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule // ccrc_properties
bind ccrc_accel ccrc_properties u_props (.sys_clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_o, .wb_ack_o, .busy_o);
`default_nettype wire

// File: checksum_crc_accelerator_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH %0t value %h expected %h", $time, a, e); end end
module checksum_crc_accelerator_test;
	localparam logic [17:0] CT = 18'h2_81EC;
	localparam logic [17:0] D0 = 18'h2_81F0;
	logic        sys_clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy_o, cy, nocy, rev, seed;
	logic [17:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, res, e, q[$];
	logic [2:0]  md;
	logic [1:0]  ws;
	int          n_errors, check_count;
	ccrc_accel dut (.sys_clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .busy_o);
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		if (wb_ack_o && !wb_we_i) begin
			e = q.pop_front();
			`CHK(wb_dat_o, e)
		end
	end
	task automatic wb(input logic [17:0] a, input logic w, input logic [31:0] d, input logic [3:0] s, input logic b);
		@(posedge sys_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
		do @(posedge sys_clk_i); while (!wb_ack_o);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		`CHK(busy_o, b)
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] x);
		q.push_back(x);
		wb(a, 1'b0, 32'h0000_0000, 4'hF, 1'b0);
	endtask
	task automatic rb;
		for (int b = 0; b < 4; b++) rd(D0 + 18'(4 * b), {24'h00_0000, res[8*b +: 8]});
	endtask
	task automatic ctl(input logic [2:0] m);
		wb(CT, 1'b1, {24'h00_0000, ws, rev, seed, nocy, m}, 4'h1, 1'b0);
		if (m != 3'h7) md = m;
		else {cy, res} = md == 3'h5 ? 33'h0_FFFF_FFFF : md inside {3'h3, 3'h4} ? 33'h0_FFFF : 33'h0;
	endtask
	task automatic put(input logic [31:0] d);
		logic [31:0] x, y;
		logic        f;
		int          n;
		n = 8 * ws + 8;
		x = d & (32'hFFFF_FFFF >> (32 - n));
		y = 32'h0000_0000;
		// high lanes first, only what the width uses
		for (int b = ws; b >= 0; b--) wb(D0 + 18'(4 * b), 1'b1, {24'h00_0000, d[8*b +: 8]}, 4'h1,
			b == 0 && !seed && md != 3'h0 && md != 3'h6);
		for (int i = 0; i < n; i++) y[i] = rev ? x[n - 1 - i] : x[i];
		if (seed && md != 3'h0) {cy, res} = {1'b0, x};
		else if (md == 3'h1) begin
			{cy, res[7:0]} = res[7:0] + y[7:0] + (cy & !nocy);
			res[31:8] = 24'h00_0000;
		end
		else if (md == 3'h2) {cy, res} = res + y + (cy & !nocy);
		else if (md inside {3'h3, 3'h4, 3'h5}) for (int i = n - 1; i >= 0; i--) begin
			f = res[md == 3'h5 ? 31 : 15] ^ y[i];
			res = (res << 1) & (md == 3'h5 ? 32'hFFFF_FFFF : 32'h0000_FFFF);
			if (f) res = res ^ (md == 3'h3 ? 32'h0000_8005 : md == 3'h4 ? 32'h0000_1021 : 32'h04C1_1DB7);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#500_000;
		n_errors++;
		end_sim;
	end
	initial begin
		{srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 57'h0};
		{res, cy, md, ws, nocy, rev, seed} = 41'h0;
		void'($urandom(49580));
		repeat (16) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(CT, 32'h0000_0000);
		rb;
		rd(18'h0_0100, 32'h0000_0000);
		// every mode, flags random; clear after the first mode set of each pass, not after the seed pass rewrites
		for (int k = 0; k < 27; k++) begin
			{ws, rev, nocy} = 4'($urandom);
			ctl(3'(k % 7));
			ctl(3'h7);
			rd(CT, {23'h00_0000, 1'b0, ws, rev, seed, nocy, 3'h7});
			if (k % 3 == 0) begin
				seed = 1'b1;
				ctl(3'(k % 7));
				put($urandom);
				seed = 1'b0;
				ctl(3'(k % 7));
			end
			repeat (3) put($urandom);
			rb;
		end
		wb(D0, 1'b1, 32'h0000_005A, 4'hE, 1'b0);
		rb;
		end_sim;
	end
endmodule // checksum_crc_accelerator_test
`default_nettype wire
